// ---- core/rssi_top.sv ----
// status lamps, blink timebase and service-port mode of a ring substation
// assumes status inputs come from logic on clk_sys_i; rotary pins are async
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module rssi_top
#(
  parameter int unsigned BLINK_HALF = rssi_pkg::BLINK_HALF_CYC,
  parameter int unsigned DEB_CYC = rssi_pkg::DEBOUNCE_CYC,
  parameter int NPORT = 3
)(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic irq_o,
  // module status conditions
  input wire logic run_ok_i,
  input wire logic params_loaded_i,
  input wire logic io_link_any_i,
  input wire logic fault_i,
  input wire logic svc_link_i,
  input wire logic ring1_ok_i,
  input wire logic ring2_ok_i,
  input wire logic master_ok_i,
  input wire logic ip_conflict_i,
  input wire logic [NPORT-1:0] port_link_i,
  input wire logic [NPORT-1:0] port_speed100_i,
  input wire logic [NPORT-1:0] port_activity_i,
  // rotary pins
  input wire logic [3:0] rotary_low_digit_i,
  input wire logic [3:0] rotary_high_digit_i,
  // traffic towards the service port
  input wire logic [7:0] svc_fab_data_i,
  input wire logic svc_fab_valid_i,
  input wire logic [7:0] ring1_data_i,
  input wire logic ring1_valid_i,
  input wire logic [7:0] ring2_data_i,
  input wire logic ring2_valid_i,
  output logic [7:0] svc_tx_data_o,
  output logic svc_tx_valid_o,
  output logic mirror_mode_o,
  // lamps
  output logic power_lamp_o,
  output logic run_lamp_o,
  output logic io_link_lamp_o,
  output logic fault_lamp_o,
  output logic service_port_lamp_o,
  output logic ring_port_one_lamp_o,
  output logic ring_port_two_lamp_o,
  output logic master_comm_lamp_o,
  output logic module_state_lamp_o,
  output logic [NPORT-1:0] speed_lamp_o,
  output logic [NPORT-1:0] activity_lamp_o
);
  import rssi_pkg::*;

  // one lamp: blinking wins over steady, otherwise steady or dark
  function automatic logic lamp_sel(input logic on, input logic blink,
                                    input logic phase);
    lamp_sel = blink ? phase : on;
  endfunction

  // ==========================================================
  // reset release
  logic rst_meta_reg;
  logic rst_n;
  // release through two flops so all flops leave reset together
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ==========================================================
  // shared half-second timebase
  logic [31:0] half_cnt_reg;
  logic blink_reg;
  wire tick = (half_cnt_reg == BLINK_HALF - 32'd1);
  wire period_end = tick & blink_reg;
  // free running; every blinking lamp shares this phase
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_cnt_reg <= 32'h0;
      blink_reg <= 1'b0;
    end
    else
    begin
      half_cnt_reg <= tick ? 32'h0 : half_cnt_reg + 32'h1;
      blink_reg <= tick ? ~blink_reg : blink_reg;
    end
  end

  // ==========================================================
  // rotary switch capture
  logic [7:0] sw_meta_reg;
  logic [7:0] sw_sync_reg;
  logic [7:0] sw_cand_reg;
  logic [7:0] sw_stable_reg;
  logic [7:0] sw_latched_reg;
  logic [31:0] deb_cnt_reg;
  logic deb_valid_reg;
  logic latched_valid_reg;
  logic sw_changed_reg;
  wire deb_done = (deb_cnt_reg == DEB_CYC);
  wire sw_moving = (sw_sync_reg != sw_cand_reg);
  // a value counts only after holding still for the debounce time
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_meta_reg <= 8'h00;
      sw_sync_reg <= 8'h00;
      sw_cand_reg <= 8'h00;
      sw_stable_reg <= 8'h00;
      deb_cnt_reg <= 32'h0;
      deb_valid_reg <= 1'b0;
    end
    else
    begin
      sw_meta_reg <= {rotary_high_digit_i, rotary_low_digit_i};
      sw_sync_reg <= sw_meta_reg;
      sw_cand_reg <= sw_sync_reg;
      deb_cnt_reg <= (sw_moving || deb_done) ? 32'h0 : deb_cnt_reg + 32'h1;
      if (deb_done && !sw_moving)
      begin
        sw_stable_reg <= sw_cand_reg;
        deb_valid_reg <= 1'b1;
      end
    end
  end
  // the first settled value after restart is kept until next restart
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_latched_reg <= 8'h00;
      latched_valid_reg <= 1'b0;
      sw_changed_reg <= 1'b0;
    end
    else
    begin
      if (deb_valid_reg && !latched_valid_reg)
      begin
        sw_latched_reg <= sw_stable_reg;
        latched_valid_reg <= 1'b1;
      end
      if (latched_valid_reg && sw_stable_reg != sw_latched_reg)
        sw_changed_reg <= 1'b1;
    end
  end

  // ==========================================================
  // service port mode and traffic
  wire [3:0] lat_low = sw_latched_reg[3:0];
  wire [3:0] lat_high = sw_latched_reg[7:4];
  wire is_mirror = latched_valid_reg && (lat_low == DIGIT_MIRROR);
  wire is_access = latched_valid_reg && (lat_low == DIGIT_ZERO) &&
                   (lat_high == DIGIT_ZERO);
  rssi_mode_e mode;
  assign mode = is_mirror ? RSSI_MODE_MIRROR :
                is_access ? RSSI_MODE_ACCESS : RSSI_MODE_OTHER;
  // mirror has no buffer: ring 1 wins a cycle where both carry data,
  // so a monitor sees every byte only while the ports do not overlap
  wire [7:0] mir_data = ring1_valid_i ? ring1_data_i : ring2_data_i;
  wire mir_valid = ring1_valid_i | ring2_valid_i;
  wire use_mirror = (mode == RSSI_MODE_MIRROR);
  wire [7:0] tx_data = use_mirror ? mir_data : svc_fab_data_i;
  wire tx_valid = use_mirror ? mir_valid : svc_fab_valid_i;
  // service port output stage
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      svc_tx_data_o <= 8'h00;
      svc_tx_valid_o <= 1'b0;
      mirror_mode_o <= 1'b0;
    end
    else
    begin
      svc_tx_data_o <= tx_data;
      svc_tx_valid_o <= tx_valid;
      mirror_mode_o <= use_mirror;
    end
  end

  // ==========================================================
  // front panel lamps
  wire ph = blink_reg;
  wire run_lamp = lamp_sel(run_ok_i, run_ok_i & params_loaded_i,
                           ph);
  wire master_lamp = lamp_sel(1'b1, ~master_ok_i, ph);
  wire state_lamp = lamp_sel(sw_changed_reg, ip_conflict_i,
                             ph);
  // lamps registered so every output comes from a flop
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_lamp_o <= 1'b0;
      run_lamp_o <= 1'b0;
      io_link_lamp_o <= 1'b0;
      fault_lamp_o <= 1'b0;
      service_port_lamp_o <= 1'b0;
      ring_port_one_lamp_o <= 1'b0;
      ring_port_two_lamp_o <= 1'b0;
      master_comm_lamp_o <= 1'b0;
      module_state_lamp_o <= 1'b0;
    end
    else
    begin
      power_lamp_o <= 1'b1;
      run_lamp_o <= run_lamp;
      io_link_lamp_o <= io_link_any_i;
      fault_lamp_o <= fault_i;
      service_port_lamp_o <= svc_link_i;
      ring_port_one_lamp_o <= ring1_ok_i;
      ring_port_two_lamp_o <= ring2_ok_i;
      master_comm_lamp_o <= master_lamp;
      module_state_lamp_o <= state_lamp;
    end
  end

  // ==========================================================
  // per-port speed and activity lamps
  logic [NPORT-1:0] act_hold_reg;
  logic [NPORT-1:0] act_lamp;
  // activity is held until the blink period ends so short bursts show
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
      act_lamp[p] = lamp_sel(port_link_i[p], port_link_i[p] &
                             act_hold_reg[p], ph);
  end
  // a new burst at period end is kept: the set wins over the clear
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_hold_reg <= '0;
      speed_lamp_o <= '0;
      activity_lamp_o <= '0;
    end
    else
    begin
      act_hold_reg <= port_activity_i |
                      (act_hold_reg & ~{NPORT{period_end}});
      speed_lamp_o <= port_link_i & port_speed100_i;
      activity_lamp_o <= act_lamp;
    end
  end

  // ==========================================================
  // events and interrupt
  logic [EV_W-1:0] ev_prev_reg;
  logic [EV_W-1:0] status_reg;
  logic [EV_W-1:0] mask_reg;
  wire [EV_W-1:0] ev_lvl = {~master_ok_i, fault_i, sw_changed_reg,
                            ip_conflict_i};
  wire [EV_W-1:0] ev_rise = ev_lvl & ~ev_prev_reg;

  // ==========================================================
  // ahb-lite slave, zero wait states
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  wire take = hsel_i & htrans_i[1] & hready_i;
  wire [7:0] a_addr = haddr_i[7:0];
  wire hit_hi = (haddr_i[31:8] == 24'h0);
  wire wr_status = wr_pend_reg && (wr_addr_reg == ADDR_STATUS);
  wire wr_mask = wr_pend_reg && (wr_addr_reg == ADDR_MASK);
  wire [EV_W-1:0] w1c = wr_status ? hwdata_i[EV_W-1:0] : '0;
  wire [EV_W-1:0] status_next = (status_reg & ~w1c) | ev_rise;
  wire [31:0] lamps_rd = {17'h0, activity_lamp_o, speed_lamp_o,
                          module_state_lamp_o, master_comm_lamp_o,
                          ring_port_two_lamp_o, ring_port_one_lamp_o,
                          service_port_lamp_o, fault_lamp_o,
                          io_link_lamp_o, run_lamp_o, power_lamp_o};
  wire [31:0] switch_rd = {12'h0, mode, sw_changed_reg, latched_valid_reg,
                           sw_latched_reg, sw_stable_reg};
  wire [31:0] rd_data = !hit_hi ? 32'h0 :
                        (a_addr == ADDR_STATUS) ? {28'h0, status_reg} :
                        (a_addr == ADDR_MASK) ? {28'h0, mask_reg} :
                        (a_addr == ADDR_LAMPS) ? lamps_rd :
                        (a_addr == ADDR_SWITCH) ? switch_rd : 32'h0;

  // address phase captured; write data used in the following cycle
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_o <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= take & hwrite_i & hit_hi;
      wr_addr_reg <= take ? a_addr : wr_addr_reg;
      hrdata_o <= (take & ~hwrite_i) ? rd_data : hrdata_o;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end
  // sticky status, mask and interrupt output
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ev_prev_reg <= '0;
      status_reg <= STATUS_RST;
      mask_reg <= MASK_RST;
      irq_o <= 1'b0;
    end
    else
    begin
      ev_prev_reg <= ev_lvl;
      status_reg <= status_next;
      mask_reg <= wr_mask ? hwdata_i[EV_W-1:0] : mask_reg;
      irq_o <= |(status_reg & mask_reg);
    end
  end

  // ==========================================================
  // checks
  default clocking cb_sys @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);
  a_blink_toggle: assert property (tick |=>
    blink_reg != $past(blink_reg))
    else $error("blink phase did not toggle");
  a_power_on: assert property ($past(rst_n) |-> power_lamp_o)
    else $error("power lamp dark while powered");
  a_run_steady: assert property (run_ok_i && !params_loaded_i |=>
    run_lamp_o)
    else $error("run lamp not steady without parameters");
  a_master_blink: assert property (!master_ok_i |=>
    master_comm_lamp_o == $past(blink_reg))
    else $error("master lamp not blinking on loss");
  a_state_conf: assert property (ip_conflict_i |=>
    module_state_lamp_o == $past(blink_reg))
    else $error("state lamp not blinking on conflict");
  a_speed_lamp: assert property (port_link_i[0] &&
    !port_speed100_i[0] |=> !speed_lamp_o[0])
    else $error("speed lamp lit at 10 mbps");
  a_mirror_mode: assert property (latched_valid_reg &&
    lat_low == DIGIT_MIRROR |=> mirror_mode_o)
    else $error("low digit f did not select mirror");
  a_latch_hold: assert property (latched_valid_reg |=>
    $stable(sw_latched_reg))
    else $error("latched switch value changed without restart");
  a_mirror_copy: assert property (use_mirror && ring2_valid_i &&
    !ring1_valid_i |=> svc_tx_valid_o &&
    svc_tx_data_o == $past(ring2_data_i))
    else $error("ring 2 traffic not copied");
  a_fault_lamp: assert property (fault_i [*2] |-> fault_lamp_o)
    else $error("fault lamp dark during fault");

endmodule

// ---- include/rssi_pkg.sv ----
// constants for the substation lamp and service-port mode block
// assumes a 200 MHz system clock and a 32-bit AHB-Lite register bus
package rssi_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_LAMPS = 8'h08;
  localparam logic [7:0] ADDR_SWITCH = 8'h0c;

  // ==========================================================
  // status and mask bit positions
  localparam int EV_W = 4;
  localparam int EV_IP_CONFLICT = 0;
  localparam int EV_SW_CHANGED = 1;
  localparam int EV_FAULT = 2;
  localparam int EV_MASTER_LOST = 3;
  localparam logic [EV_W-1:0] STATUS_RST = 4'h0;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;

  // ==========================================================
  // rotary switch codes
  localparam logic [3:0] DIGIT_ZERO = 4'h0;
  localparam logic [3:0] DIGIT_MIRROR = 4'hf;

  // service port modes
  typedef enum logic [1:0] {
    RSSI_MODE_ACCESS = 2'b00,
    RSSI_MODE_MIRROR = 2'b01,
    RSSI_MODE_OTHER = 2'b10
  } rssi_mode_e;

endpackage

// ---- dv/rssi_far_side.sv ----
// far-side model: the two rotary switch digits and both ring ports
// assumes the bench steps the dial and asks for single ring bytes
`timescale 1ns/1ps
module rssi_far_side (
  input wire logic clk_i,
  input wire logic [3:0] dial_low_i,
  input wire logic [3:0] dial_high_i,
  input wire logic send1_i,
  input wire logic send2_i,
  output logic [3:0] rotary_low_digit_o,
  output logic [3:0] rotary_high_digit_o,
  output logic [7:0] ring1_data_o,
  output logic [7:0] ring2_data_o,
  output logic ring1_valid_o,
  output logic ring2_valid_o
);
  logic [7:0] dial_prev = 8'h00;
  logic [1:0] bounce = 2'h0;
  logic [7:0] seq1 = 8'h10;
  logic [7:0] seq2 = 8'h80;

  // ========================================================
  // switch contacts chatter for a few cycles after each turn
  initial {rotary_high_digit_o, rotary_low_digit_o} = 8'h00;
  always @(posedge clk_i)
  begin
    dial_prev <= {dial_high_i, dial_low_i};
    if (dial_prev != {dial_high_i, dial_low_i})
      bounce <= 2'h3;
    else if (bounce != 2'h0)
      bounce <= bounce - 2'h1;
    if (bounce[0])
      {rotary_high_digit_o, rotary_low_digit_o} <= ~dial_prev;
    else
      {rotary_high_digit_o, rotary_low_digit_o} <= dial_prev;
  end

  // ========================================================
  // ring bytes; an idle line toggles every data bit each cycle
  initial {ring1_valid_o, ring2_valid_o} = 2'b00;
  initial {ring1_data_o, ring2_data_o} = 16'h0000;
  always @(posedge clk_i)
  begin
    ring1_valid_o <= send1_i;
    ring2_valid_o <= send2_i;
    ring1_data_o <= send1_i ? seq1 : ~ring1_data_o;
    ring2_data_o <= send2_i ? seq2 : ~ring2_data_o;
    if (send1_i)
      seq1 <= seq1 + 8'h01;
    if (send2_i)
      seq2 <= seq2 + 8'h01;
  end
endmodule

// ---- dv/rssi_top_tb_top.sv ----
// self-checking bench for the substation lamp and mode block
// assumes short blink and debounce counts, hready looped from hreadyout
`timescale 1ns/1ps
module rssi_top_tb_top;
  import rssi_pkg::*;
  localparam int BH = 8;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic hreadyout, hresp, irq;
  logic run_ok = 0, prm = 0, io = 0, flt = 0, svc = 0, r1 = 0, r2 = 0;
  logic mst = 1, ipc = 0, fabv = 0, s1 = 0, s2 = 0;
  logic [2:0] lnk = 0, spd = 0, act = 0;
  logic [3:0] dlo = 0, dhi = 0, rlo, rhi;
  logic [7:0] fab = 0, d1, d2, txd;
  logic v1, v2, txv, mir;
  wire [14:0] lamps;
  int failures = 0;
  int total_checks = 0;

  // ========================================================
  // clock, far side and design
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  rssi_far_side far (.clk_i(clk_sys_i), .dial_low_i(dlo),
    .dial_high_i(dhi), .send1_i(s1), .send2_i(s2),
    .rotary_low_digit_o(rlo), .rotary_high_digit_o(rhi),
    .ring1_data_o(d1), .ring2_data_o(d2), .ring1_valid_o(v1),
    .ring2_valid_o(v2));
  rssi_top #(.BLINK_HALF(BH), .DEB_CYC(4), .NPORT(3)) uut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .irq_o(irq), .run_ok_i(run_ok), .params_loaded_i(prm),
    .io_link_any_i(io), .fault_i(flt), .svc_link_i(svc),
    .ring1_ok_i(r1), .ring2_ok_i(r2), .master_ok_i(mst),
    .ip_conflict_i(ipc), .port_link_i(lnk), .port_speed100_i(spd),
    .port_activity_i(act), .rotary_low_digit_i(rlo),
    .rotary_high_digit_i(rhi), .svc_fab_data_i(fab),
    .svc_fab_valid_i(fabv), .ring1_data_i(d1), .ring1_valid_i(v1),
    .ring2_data_i(d2), .ring2_valid_i(v2), .svc_tx_data_o(txd),
    .svc_tx_valid_o(txv), .mirror_mode_o(mir),
    .power_lamp_o(lamps[0]), .run_lamp_o(lamps[1]),
    .io_link_lamp_o(lamps[2]), .fault_lamp_o(lamps[3]),
    .service_port_lamp_o(lamps[4]), .ring_port_one_lamp_o(lamps[5]),
    .ring_port_two_lamp_o(lamps[6]), .master_comm_lamp_o(lamps[7]),
    .module_state_lamp_o(lamps[8]), .speed_lamp_o(lamps[11:9]),
    .activity_lamp_o(lamps[14:12]));

  // ========================================================
  // shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // lit cycles over one whole blink period: 0, BH or 2*BH
  task automatic watch(input int idx, input int exp);
    int ons;
    ons = 0;
    repeat (2 * BH)
    begin
      tick(1);
      if (lamps[idx] === 1'b1)
        ons++;
    end
    chk(ons, exp);
  endtask
  // one single word transfer; waits for hready in both phases
  task automatic ahb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk_sys_i);
    while (hreadyout !== 1'b1) @(posedge clk_sys_i);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk_sys_i);
    while (hreadyout !== 1'b1) @(posedge clk_sys_i);
    rd = hrdata;
  endtask
  task automatic restart(input logic [3:0] lo, input logic [3:0] hi);
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    dlo <= lo;
    dhi <= hi;
    repeat (12) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    tick(30);
  endtask

  // ========================================================
  // scenarios
  task automatic t_power;
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    tick(2);
    chk(lamps[0], 1'b0);
    restart(4'h0, 4'h0);
    chk(lamps[0], 1'b1);
    ahb(1'b0, ADDR_LAMPS, 32'h0);
    chk(rd[0], 1'b1);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 1'b0);
  endtask
  task automatic t_run;
    @(posedge clk_sys_i);
    run_ok <= 1'b1;
    prm <= 1'b1;
    tick(2);
    watch(1, BH);
    @(posedge clk_sys_i);
    prm <= 1'b0;
    tick(2);
    watch(1, 2 * BH);
    @(posedge clk_sys_i);
    run_ok <= 1'b0;
    tick(2);
    watch(1, 0);
  endtask
  task automatic t_static;
    logic [4:0] pat [4] = '{5'h15, 5'h0a, 5'h1f, 5'h00};
    foreach (pat[i])
    begin
      @(posedge clk_sys_i);
      {r2, r1, svc, flt, io} <= pat[i];
      tick(2);
      chk(lamps[6:2], pat[i]);
    end
  endtask
  task automatic t_master;
    @(posedge clk_sys_i);
    mst <= 1'b0;
    tick(2);
    watch(7, BH);
    ahb(1'b1, ADDR_MASK, 32'h8);
    tick(2);
    chk(irq, 1'b1);
    @(posedge clk_sys_i);
    mst <= 1'b1;
    ahb(1'b1, ADDR_STATUS, 32'h8);
    tick(2);
    chk(irq, 1'b0);
    watch(7, 2 * BH);
  endtask
  task automatic t_ports;
    @(posedge clk_sys_i);
    lnk <= 3'b011;
    spd <= 3'b110;
    act <= 3'b001;
    tick(2 * BH);
    chk(lamps[11:9], 3'b010);
    watch(12, BH);
    watch(13, 2 * BH);
    watch(14, 0);
  endtask
  task automatic t_mirror;
    restart(4'hf, 4'h7);
    chk(mir, 1'b1);
    ahb(1'b0, ADDR_SWITCH, 32'h0);
    chk(rd[19:16], 4'b0101);
    @(posedge clk_sys_i);
    s1 <= 1'b1;
    @(posedge clk_sys_i);
    s1 <= 1'b0;
    s2 <= 1'b1;
    tick(1);
    chk({txv, txd}, 9'h110);
    @(posedge clk_sys_i);
    s2 <= 1'b0;
    #1;
    chk({txv, txd}, 9'h180);
    @(posedge clk_sys_i);
    dlo <= 4'h0;
    tick(30);
    chk(mir, 1'b1);
    watch(8, 2 * BH);
    ahb(1'b1, ADDR_MASK, 32'h2);
    tick(2);
    chk(irq, 1'b1);
    ahb(1'b1, ADDR_STATUS, 32'h2);
    tick(2);
    chk(irq, 1'b0);
    @(posedge clk_sys_i);
    ipc <= 1'b1;
    tick(2);
    watch(8, BH);
    @(posedge clk_sys_i);
    ipc <= 1'b0;
  endtask
  task automatic t_access;
    restart(4'h3, 4'h1);
    ahb(1'b0, ADDR_SWITCH, 32'h0);
    chk({mir, rd[19:18]}, 3'b010);
    restart(4'h0, 4'h0);
    chk({mir, lamps[8]}, 2'b00);
    @(posedge clk_sys_i);
    fab <= 8'h3c;
    fabv <= 1'b1;
    s1 <= 1'b1;
    @(posedge clk_sys_i);
    fabv <= 1'b0;
    s1 <= 1'b0;
    #1;
    chk({txv, txd}, 9'h13c);
    tick(1);
    chk(txv, 1'b0);
  endtask

  // ========================================================
  // verdict, main sequence and watchdog
  task automatic give_verdict;
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    t_power();
    t_run();
    t_static();
    t_master();
    t_ports();
    t_mirror();
    t_access();
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    give_verdict();
  end
endmodule
